// >>> rfsw_ctrl.sv
// Antenna diversity switch and front-end indicator control with its register file.
`timescale 1ns/1ps

// Notes on behaviour
// - Four-bit correlator threshold resets to 0x7; 0x3 is the diversity setting.
// - Read-only bit 7 reports the static antenna, or with auto on the antenna of the last header lock.
// - Bit 3 enables autonomous antenna choice during header search.
// - Auto choice held until new search, leaving receive, or static write.
// - Bit 2 drives complementary switch pins selecting the chosen antenna.
// - Enabled switch pins stay driven in every state, including sleep.
// - With the switch enable clear both switch pins are pulled low.
// - Static field: 1 antenna one, 2 antenna zero, 0 reserved, 3 default.
// - Static selection reaches pins only in synth-on, receive or transmit.
// - Indicator enable drives pin a high from modulation start, less the lead time, until transmit-busy is left, else pin b high.
// - With indicator enable clear both indicator pins are held low.
// - Rising transmit edge in synth-on enters transmit-busy; modulation after 16 us.
// - Lead-time fields shift the indicator switching moment.
// - With auto on, status holds after a frame and updates only on a new header lock.
module rfsw_ctrl
	import rfsw_pkg::*;
#(
	parameter int MOD_CYCLES = MODULATION_DELAY_CYCLES
)(
	input  wire logic              ref_clk,
	input  wire logic              rst,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [DATA_W-1:0] reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [DATA_W-1:0] reg_rdata,
	input  wire logic [STATE_W-1:0] trx_state_in,
	input  wire logic              sleep_transmit_control_pin,
	input  wire logic              header_search_start,
	input  wire logic              header_lock,
	input  wire logic              header_lock_antenna,
	input  wire logic [LEAD_W-1:0] amp_lead_time,
	input  wire logic [LEAD_W-1:0] amp_buffer_lead_time,
	output logic                   tx_start_req,
	output logic                   modulation_start,
	output logic                   antenna_switch_pin_a,
	output logic                   antenna_switch_pin_b,
	output logic                   antenna_switch_oe,
	output logic                   frontend_indicator_pin_a,
	output logic                   frontend_indicator_pin_b,
	output logic                   frontend_indicator_oe,
	output logic [THRESHOLD_W-1:0] correlator_threshold,
	output logic                   rx_start_timestamp_pin_enable
);

	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed {
		logic [DATA_W-1:0]          ctrl_one;
		logic [THRESHOLD_W-1:0]     threshold;
		logic                       auto_en;
		logic                       sw_en;
		logic [STATIC_SELECT_W-1:0] static_sel;
		logic [STATIC_SELECT_W-1:0] applied_sel;
		logic                       auto_ant;
		logic                       auto_valid;
		logic                       status_ant;
		logic                       slp_prev;
		logic                       tx_busy;
		logic [COUNT_W-1:0]         mod_cnt;
		logic [COUNT_W-1:0]         ind_cnt;
		logic                       ind_tx;
		logic [DATA_W-1:0]          rdata;
		logic                       tx_req;
		logic                       mod_start;
		logic                       sw_a;
		logic                       sw_b;
		logic                       sw_oe;
		logic                       ind_a;
		logic                       ind_b;
		logic                       ind_oe;
	} rfsw_state_t;

	rfsw_state_t cur;
	rfsw_state_t next_cur;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic rfsw_in_rx(input logic [STATE_W-1:0] st);
		return (st == RFSW_ST_RX_ON) || (st == RFSW_ST_RX_BUSY);
	endfunction

	function automatic logic rfsw_static_ant(input logic [STATIC_SELECT_W-1:0] sel);
		return sel == STATIC_ANTENNA_ONE;
	endfunction

	logic                   wr_ctrl_one;
	logic                   wr_ant;
	logic                   active_state;
	logic                   ant_now;
	int                     lead_cycles;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		next_cur     = cur;
		wr_ctrl_one  = reg_wr && (reg_addr == TRANSCEIVER_CONTROL_ONE_ADDR);
		wr_ant       = reg_wr && (reg_addr == ANTENNA_SELECTION_CONTROL_ADDR);
		active_state = (trx_state_in == RFSW_ST_SYNTH_ON) || rfsw_in_rx(trx_state_in)
			|| (trx_state_in == RFSW_ST_TX_BUSY);
		lead_cycles  = LEAD_STEP_CYCLES * (int'(amp_buffer_lead_time) + int'(amp_lead_time));

		if (wr_ctrl_one) begin
			next_cur.ctrl_one = reg_wdata;
		end
		if (reg_wr && (reg_addr == RECEIVER_CONTROL_ADDR)) begin
			next_cur.threshold = reg_wdata[THRESHOLD_LSB +: THRESHOLD_W];
		end
		if (wr_ant) begin
			next_cur.auto_en    = reg_wdata[AUTO_ANTENNA_SELECT_ENABLE_BIT];
			next_cur.sw_en      = reg_wdata[ANTENNA_SWITCH_OUTPUT_ENABLE_BIT];
			next_cur.static_sel = reg_wdata[STATIC_SELECT_LSB +: STATIC_SELECT_W];
		end

		// Automatic choice, dropped on new search, leaving receive or static write.
		if (wr_ant || header_search_start || !rfsw_in_rx(trx_state_in)) begin
			next_cur.auto_valid = 1'b0;
		end
		if (cur.auto_en && header_lock && rfsw_in_rx(trx_state_in)) begin
			next_cur.auto_ant   = header_lock_antenna;
			next_cur.auto_valid = 1'b1;
			next_cur.status_ant = header_lock_antenna;
		end else if (!cur.auto_en) begin
			next_cur.status_ant = rfsw_static_ant(cur.applied_sel);
		end

		// Static selection takes effect only in active states.
		if (active_state) begin
			next_cur.applied_sel = cur.static_sel;
		end

		ant_now = (cur.auto_en && cur.auto_valid) ? cur.auto_ant : rfsw_static_ant(cur.applied_sel);
		if (cur.sw_en) begin
			next_cur.sw_oe = 1'b1;
			if (cur.auto_en && cur.auto_valid) begin
				next_cur.sw_a = !ant_now;
				next_cur.sw_b = ant_now;
			end else begin
				// Value 3 and reserved 0 leave antenna zero selected.
				next_cur.sw_a = (cur.applied_sel != STATIC_ANTENNA_ONE);
				next_cur.sw_b = (cur.applied_sel == STATIC_ANTENNA_ONE);
			end
		end else begin
			next_cur.sw_oe = 1'b0;
			next_cur.sw_a  = 1'b0;
			next_cur.sw_b  = 1'b0;
		end

		// Transmit start on rising edge in synth-on.
		next_cur.slp_prev  = sleep_transmit_control_pin;
		next_cur.tx_req    = 1'b0;
		next_cur.mod_start = 1'b0;
		if (sleep_transmit_control_pin && !cur.slp_prev && (trx_state_in == RFSW_ST_SYNTH_ON)) begin
			next_cur.tx_req  = 1'b1;
			next_cur.tx_busy = 1'b1;
			next_cur.mod_cnt = COUNT_W'(MOD_CYCLES - 1);
			next_cur.ind_cnt = (lead_cycles >= MOD_CYCLES) ? '0
				: COUNT_W'(MOD_CYCLES - 1 - lead_cycles);
		end else if (cur.tx_busy) begin
			if (cur.mod_cnt != '0) begin
				next_cur.mod_cnt = cur.mod_cnt - COUNT_W'(1);
			end else begin
				next_cur.mod_start = 1'b1;
				next_cur.tx_busy   = 1'b0;
			end
			if (cur.ind_cnt != '0) begin
				next_cur.ind_cnt = cur.ind_cnt - COUNT_W'(1);
			end else begin
				next_cur.ind_tx = 1'b1;
			end
		end
		if (trx_state_in != RFSW_ST_TX_BUSY && !cur.tx_busy && !next_cur.tx_busy) begin
			next_cur.ind_tx = 1'b0;
		end

		if (cur.ctrl_one[FRONTEND_INDICATOR_ENABLE_BIT]) begin
			next_cur.ind_oe = 1'b1;
			next_cur.ind_a  = cur.ind_tx;
			next_cur.ind_b  = !cur.ind_tx;
		end else begin
			next_cur.ind_oe = 1'b0;
			next_cur.ind_a  = 1'b0;
			next_cur.ind_b  = 1'b0;
		end

		// Read data stands only in the cycle after the read strobe.
		next_cur.rdata = '0;
		if (reg_rd) begin
			unique case (reg_addr)
				TRANSCEIVER_CONTROL_ONE_ADDR: next_cur.rdata = cur.ctrl_one;
				RECEIVER_CONTROL_ADDR:        next_cur.rdata = {4'h0, cur.threshold};
				ANTENNA_SELECTION_CONTROL_ADDR: begin
					next_cur.rdata[SELECTED_ANTENNA_STATUS_BIT]      = cur.status_ant;
					next_cur.rdata[AUTO_ANTENNA_SELECT_ENABLE_BIT]   = cur.auto_en;
					next_cur.rdata[ANTENNA_SWITCH_OUTPUT_ENABLE_BIT] = cur.sw_en;
					next_cur.rdata[STATIC_SELECT_LSB +: STATIC_SELECT_W] = cur.static_sel;
				end
				TRANSCEIVER_STATE_ADDR:       next_cur.rdata = {5'h00, trx_state_in};
				default:                      next_cur.rdata = '0;
			endcase
		end
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			cur             <= '0;
			cur.ctrl_one    <= TRANSCEIVER_CONTROL_ONE_RESET;
			cur.threshold   <= THRESHOLD_RESET;
			cur.static_sel  <= STATIC_DEFAULT;
			cur.applied_sel <= STATIC_DEFAULT;
		end else begin
			cur <= next_cur;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign reg_rdata                     = cur.rdata;
	assign tx_start_req                  = cur.tx_req;
	assign modulation_start              = cur.mod_start;
	assign antenna_switch_pin_a          = cur.sw_a;
	assign antenna_switch_pin_b          = cur.sw_b;
	assign antenna_switch_oe             = cur.sw_oe;
	assign frontend_indicator_pin_a      = cur.ind_a;
	assign frontend_indicator_pin_b      = cur.ind_b;
	assign frontend_indicator_oe         = cur.ind_oe;
	assign correlator_threshold          = cur.threshold;
	assign rx_start_timestamp_pin_enable = cur.ctrl_one[RX_START_TIMESTAMP_PIN_BIT];

endmodule

// >>> rfsw_ctrl_properties.sv
// Concurrent checks on the antenna switch control ports.
`timescale 1ns/1ps
module rfsw_ctrl_properties
	import rfsw_pkg::*;
#(
	parameter int MOD_CYCLES = MODULATION_DELAY_CYCLES
)(
	input wire logic                   ref_clk,
	input wire logic                   rst,
	input wire logic [ADDR_W-1:0]      reg_addr,
	input wire logic [DATA_W-1:0]      reg_wdata,
	input wire logic                   reg_wr,
	input wire logic [STATE_W-1:0]     trx_state_in,
	input wire logic                   sleep_transmit_control_pin,
	input wire logic                   tx_start_req,
	input wire logic                   modulation_start,
	input wire logic                   antenna_switch_pin_a,
	input wire logic                   antenna_switch_pin_b,
	input wire logic                   antenna_switch_oe,
	input wire logic                   frontend_indicator_pin_a,
	input wire logic                   frontend_indicator_pin_b,
	input wire logic                   frontend_indicator_oe,
	input wire logic [THRESHOLD_W-1:0] correlator_threshold
);
	// ------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------
	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);
	wire logic wr_sel = reg_wr && reg_addr == ANTENNA_SELECTION_CONTROL_ADDR;
	wire logic wr_thr = reg_wr && reg_addr == RECEIVER_CONTROL_ADDR;
	a_switch_off_low: assert property (!antenna_switch_oe |-> !antenna_switch_pin_a && !antenna_switch_pin_b)
		else $error("switch pins not low while disabled");
	a_switch_diff: assert property (antenna_switch_oe |-> antenna_switch_pin_a != antenna_switch_pin_b)
		else $error("switch pins not complementary");
	a_switch_on_lat: assert property (wr_sel && reg_wdata[2] |-> ##2 antenna_switch_oe [*3])
		else $error("switch enable not applied");
	a_switch_off_lat: assert property (wr_sel && !reg_wdata[2] |-> ##2 !antenna_switch_oe)
		else $error("switch disable not applied");
	a_ind_off_low: assert property (!frontend_indicator_oe |-> !frontend_indicator_pin_a && !frontend_indicator_pin_b)
		else $error("indicator pins not low while disabled");
	a_ind_diff: assert property (frontend_indicator_oe |-> frontend_indicator_pin_a != frontend_indicator_pin_b)
		else $error("indicator pins not complementary");
	a_thr_reset: assert property (disable iff (1'b0) rst |=> correlator_threshold == THRESHOLD_RESET)
		else $error("threshold reset value wrong");
	a_thr_write: assert property (wr_thr |=> correlator_threshold == $past(reg_wdata[3:0]))
		else $error("threshold write lost");
	a_thr_hold: assert property (!wr_thr |=> $stable(correlator_threshold))
		else $error("threshold changed without a write");
	a_tx_start: assert property ($rose(sleep_transmit_control_pin) && trx_state_in == RFSW_ST_SYNTH_ON |=> tx_start_req)
		else $error("transmit start missing");
	a_mod_delay: assert property (tx_start_req |-> ##MOD_CYCLES modulation_start)
		else $error("modulation start delay wrong");
	c_mod: cover property (modulation_start);
	c_ant_one: cover property (antenna_switch_oe && antenna_switch_pin_b);
	c_ind_tx: cover property (frontend_indicator_pin_a);
endmodule

bind rfsw_ctrl rfsw_ctrl_properties #(.MOD_CYCLES(MOD_CYCLES)) i_rfsw_ctrl_properties (.*);

// >>> rfsw_frontend_model.sv
// Model of the external antenna switch and power amplifier on the pin side.
`timescale 1ns/1ps
module rfsw_frontend_model (
	input  wire logic antenna_switch_pin_a,
	input  wire logic antenna_switch_pin_b,
	input  wire logic frontend_indicator_pin_a,
	input  wire logic frontend_indicator_pin_b,
	output logic      antenna,
	output logic      pa_on
);
	// The switch connects antenna 1 when its second input is high; released pins are pulled low.
	assign antenna = antenna_switch_pin_b && !antenna_switch_pin_a;
	assign pa_on   = frontend_indicator_pin_a && !frontend_indicator_pin_b;
endmodule

// >>> rfsw_pkg.sv
// Package with register map, field positions, reset values and timing constants of the antenna switch control.
package rfsw_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam logic [ADDR_W-1:0] TRANSCEIVER_CONTROL_ONE_ADDR   = 8'h04;
	localparam logic [ADDR_W-1:0] RECEIVER_CONTROL_ADDR          = 8'h0A;
	localparam logic [ADDR_W-1:0] ANTENNA_SELECTION_CONTROL_ADDR = 8'h0D;
	localparam logic [ADDR_W-1:0] TRANSCEIVER_STATE_ADDR         = 8'h20;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int FRONTEND_INDICATOR_ENABLE_BIT   = 7;
	localparam int RX_START_TIMESTAMP_PIN_BIT      = 6;
	localparam int SELECTED_ANTENNA_STATUS_BIT     = 7;
	localparam int AUTO_ANTENNA_SELECT_ENABLE_BIT  = 3;
	localparam int ANTENNA_SWITCH_OUTPUT_ENABLE_BIT = 2;
	localparam int STATIC_SELECT_LSB               = 0;
	localparam int STATIC_SELECT_W                 = 2;
	localparam int THRESHOLD_LSB                   = 0;
	localparam int THRESHOLD_W                     = 4;
	localparam int STATE_W                         = 3;

	// ------------------------------------------------------------
	// Reset values and encodings
	// ------------------------------------------------------------
	localparam logic [DATA_W-1:0] TRANSCEIVER_CONTROL_ONE_RESET = 8'h20;
	localparam logic [THRESHOLD_W-1:0] THRESHOLD_RESET          = 4'h7;
	localparam logic [THRESHOLD_W-1:0] THRESHOLD_DIVERSITY      = 4'h3;
	localparam logic [STATIC_SELECT_W-1:0] STATIC_RESERVED      = 2'h0;
	localparam logic [STATIC_SELECT_W-1:0] STATIC_ANTENNA_ONE   = 2'h1;
	localparam logic [STATIC_SELECT_W-1:0] STATIC_ANTENNA_ZERO  = 2'h2;
	localparam logic [STATIC_SELECT_W-1:0] STATIC_DEFAULT       = 2'h3;

	// ------------------------------------------------------------
	// Transceiver state codes seen on the state input
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		RFSW_ST_SLEEP    = 3'b000,
		RFSW_ST_OFF      = 3'b001,
		RFSW_ST_SYNTH_ON = 3'b010,
		RFSW_ST_RX_ON    = 3'b011,
		RFSW_ST_RX_BUSY  = 3'b100,
		RFSW_ST_TX_BUSY  = 3'b101
	} rfsw_trx_state_t;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS       = 100;
	localparam int MODULATION_DELAY_US = 16;
	localparam int MODULATION_DELAY_CYCLES = (MODULATION_DELAY_US * 1000) / CLK_PERIOD_NS;
	localparam int LEAD_W              = 3;
	localparam int LEAD_STEP_CYCLES    = 20;
	localparam int COUNT_W             = 8;

endpackage

// >>> tb_rfsw_ctrl.sv
// Self-checking testbench of the antenna switch control.
`timescale 1ns/1ps
module tb_rfsw_ctrl
	import rfsw_pkg::*;
;
	localparam int MOD = 8;
	logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sleep_transmit_control_pin = 0;
	logic header_search_start = 0, header_lock = 0, header_lock_antenna = 0;
	logic tx_start_req, modulation_start, antenna_switch_pin_a, antenna_switch_pin_b, antenna_switch_oe;
	logic frontend_indicator_pin_a, frontend_indicator_pin_b, frontend_indicator_oe, rx_start_timestamp_pin_enable;
	logic antenna, pa_on;
	logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata;
	logic [2:0] trx_state_in = RFSW_ST_OFF, amp_lead_time = 0, amp_buffer_lead_time = 0;
	logic [3:0] correlator_threshold;
	wire logic [7:0] sw = {5'h0, antenna_switch_oe, antenna_switch_pin_a, antenna_switch_pin_b};
	wire logic [7:0] ind = {5'h0, frontend_indicator_oe, frontend_indicator_pin_a, frontend_indicator_pin_b};
	int mismatches = 0, check_count = 0, n;
	rfsw_ctrl #(.MOD_CYCLES(MOD)) i_rfsw_ctrl (
		.ref_clk                       (ref_clk),
		.rst                           (rst),
		.reg_addr                      (reg_addr),
		.reg_wdata                     (reg_wdata),
		.reg_wr                        (reg_wr),
		.reg_rd                        (reg_rd),
		.reg_rdata                     (reg_rdata),
		.trx_state_in                  (trx_state_in),
		.sleep_transmit_control_pin    (sleep_transmit_control_pin),
		.header_search_start           (header_search_start),
		.header_lock                   (header_lock),
		.header_lock_antenna           (header_lock_antenna),
		.amp_lead_time                 (amp_lead_time),
		.amp_buffer_lead_time          (amp_buffer_lead_time),
		.tx_start_req                  (tx_start_req),
		.modulation_start              (modulation_start),
		.antenna_switch_pin_a          (antenna_switch_pin_a),
		.antenna_switch_pin_b          (antenna_switch_pin_b),
		.antenna_switch_oe             (antenna_switch_oe),
		.frontend_indicator_pin_a      (frontend_indicator_pin_a),
		.frontend_indicator_pin_b      (frontend_indicator_pin_b),
		.frontend_indicator_oe         (frontend_indicator_oe),
		.correlator_threshold          (correlator_threshold),
		.rx_start_timestamp_pin_enable (rx_start_timestamp_pin_enable)
	);
	rfsw_frontend_model i_rfsw_frontend_model (
		.antenna_switch_pin_a     (antenna_switch_pin_a),
		.antenna_switch_pin_b     (antenna_switch_pin_b),
		.frontend_indicator_pin_a (frontend_indicator_pin_a),
		.frontend_indicator_pin_b (frontend_indicator_pin_b),
		.antenna                  (antenna),
		.pa_on                    (pa_on)
	);
	always #50 ref_clk = ~ref_clk;
	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic tick(input int k);
		repeat (k) @(posedge ref_clk);
		#1;
	endtask
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			$display("Error at %0t: got %h expected %h", $time, got, exp);
			mismatches++;
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
		tick(4);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1;
		chk(reg_rdata, exp);
	endtask
	task automatic lock(input logic ant);
		@(posedge ref_clk);
		header_lock <= 1'b1;
		header_lock_antenna <= ant;
		@(posedge ref_clk);
		header_lock <= 1'b0;
		tick(3);
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset;
		rd(8'h0A, 8'h07);
		rd(8'h0D, 8'h03);
		rd(8'h04, 8'h20);
		rd(8'h33, 8'h00);
		chk(sw, 8'h00);
		chk(ind, 8'h00);
		$display("reset test done");
	endtask
	task automatic t_static;
		wr(8'h0D, 8'h05);
		chk(sw, 8'h06);
		@(posedge ref_clk);
		trx_state_in <= RFSW_ST_SYNTH_ON;
		for (int s = 0; s < 4; s++) begin
			wr(8'h0D, 8'h04 | 8'(s));
			chk(sw, {6'h1, s != 1, s == 1});
			chk({7'h0, antenna}, {7'h0, s == 1});
			rd(8'h0D, {s == 1, 5'h01, 2'(s)});
		end
		@(posedge ref_clk);
		trx_state_in <= RFSW_ST_SLEEP;
		tick(3);
		chk(sw, 8'h06);
		wr(8'h0D, 8'h03);
		chk(sw, 8'h00);
		$display("static test done");
	endtask
	task automatic t_auto;
		@(posedge ref_clk);
		trx_state_in <= RFSW_ST_RX_ON;
		wr(8'h0A, 8'h03);
		chk({4'h0, correlator_threshold}, 8'h03);
		wr(8'h0D, 8'h0F);
		lock(1'b1);
		chk(sw, 8'h05);
		rd(8'h0D, 8'h8F);
		@(posedge ref_clk);
		header_search_start <= 1'b1;
		@(posedge ref_clk);
		header_search_start <= 1'b0;
		tick(3);
		chk(sw, 8'h06);
		rd(8'h0D, 8'h8F);
		lock(1'b1);
		chk(sw, 8'h05);
		@(posedge ref_clk);
		trx_state_in <= RFSW_ST_SYNTH_ON;
		tick(3);
		chk(sw, 8'h06);
		wr(8'h0D, 8'h03);
		wr(8'h0A, 8'h07);
		rd(8'h0A, 8'h07);
		$display("auto test done");
	endtask
	task automatic t_tx;
		wr(8'h04, 8'hA0);
		chk(ind, 8'h05);
		chk({7'h0, rx_start_timestamp_pin_enable}, 8'h00);
		@(posedge ref_clk);
		sleep_transmit_control_pin <= 1'b1;
		n = 0;
		while (tx_start_req !== 1'b1 && n < 5) begin
			tick(1);
			n++;
		end
		chk(8'(n), 8'h01);
		@(posedge ref_clk);
		trx_state_in <= RFSW_ST_TX_BUSY;
		n = 1;
		while (modulation_start !== 1'b1 && n < 40) begin
			tick(1);
			n++;
		end
		chk(8'(n), 8'(MOD));
		tick(2);
		chk(ind, 8'h06);
		chk({7'h0, pa_on}, 8'h01);
		@(posedge ref_clk);
		trx_state_in <= RFSW_ST_RX_ON;
		sleep_transmit_control_pin <= 1'b0;
		tick(4);
		chk(ind, 8'h05);
		@(posedge ref_clk);
		trx_state_in <= RFSW_ST_SYNTH_ON;
		amp_lead_time <= 3'h1;
		@(posedge ref_clk);
		sleep_transmit_control_pin <= 1'b1;
		tick(3);
		chk(ind, 8'h06);
		tick(10);
		@(posedge ref_clk);
		trx_state_in <= RFSW_ST_RX_ON;
		sleep_transmit_control_pin <= 1'b0;
		amp_lead_time <= 3'h0;
		tick(3);
		chk(ind, 8'h05);
		wr(8'h04, 8'h20);
		chk(ind, 8'h00);
		wr(8'h04, 8'h60);
		chk({7'h0, rx_start_timestamp_pin_enable}, 8'h01);
		wr(8'h04, 8'h20);
		$display("transmit test done");
	endtask
	initial begin
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		t_reset();
		t_static();
		t_auto();
		t_tx();
		wrap_up();
	end
	initial begin
		#400000;
		mismatches++;
		wrap_up();
	end
endmodule
